// File: hw/etgm_irq.sv
/*
 * Interrupt status and mask: events set sticky bits, a written one clears
 * a bit, and the level output is high while an unmasked bit is set.
 * Assumes event pulses and the write strobes come from the same clock.
 */
`timescale 1ns/1ps
module etgm_irq (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [etgm_pkg::IRQ_N-1:0] events,
	input wire logic status_wr,
	input wire logic mask_wr,
	input wire logic [etgm_pkg::IRQ_N-1:0] wdata,
	output logic [etgm_pkg::IRQ_N-1:0] status,
	output logic [etgm_pkg::IRQ_N-1:0] mask,
	output logic irq
);
	import etgm_pkg::*;

	typedef struct packed {
		logic [IRQ_N-1:0] status;
		logic [IRQ_N-1:0] mask;
	} etgm_irq_state_t;

	etgm_irq_state_t s_reg;
	etgm_irq_state_t s_next;

	// A new event beats a clear in the same cycle so that it is never lost.
	always_comb begin
		s_next = s_reg;
		if (status_wr) begin
			s_next.status = s_reg.status & ~wdata;
		end
		s_next.status = s_next.status | events;
		if (mask_wr) begin
			s_next.mask = wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign status = s_reg.status;
	assign mask = s_reg.mask;
	assign irq = |(s_reg.status & s_reg.mask);
endmodule : etgm_irq

// File: hw/etgm_lfsr.sv
/*
 * Pseudo-random word source: a 64-bit Galois shift register that steps
 * once per cycle in which advance is high.
 * Assumes the caller only needs a fresh value after each advance.
 */
`timescale 1ns/1ps
module etgm_lfsr (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic advance,
	output logic [63:0] value
);
	import etgm_pkg::*;

	typedef struct packed {
		logic [63:0] sr;
	} etgm_lfsr_state_t;

	etgm_lfsr_state_t s_reg;
	etgm_lfsr_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (advance) begin
			s_next.sr = {s_reg.sr[62:0], 1'b0} ^ (s_reg.sr[63] ? LFSR_TAPS : 64'h0);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg.sr <= LFSR_SEED;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign value = s_reg.sr;
endmodule : etgm_lfsr

// File: hw/etgm_pkg.sv
/*
 * Shared constants and types of the Ethernet traffic generator and monitor:
 * register offsets, reset values, field positions, frame layout and the
 * packet stream carrier.
 * Assumes a single clock domain and a 64-bit MAC client stream on each path.
 */
package etgm_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int REG_AW = 7;
	localparam logic [REG_AW-1:0] GEN_PACKET_COUNT = 7'h00;
	localparam logic [REG_AW-1:0] GEN_RANDOM_LENGTH_ENABLE = 7'h04;
	localparam logic [REG_AW-1:0] GEN_RANDOM_PAYLOAD_ENABLE = 7'h08;
	localparam logic [REG_AW-1:0] GEN_START = 7'h0c;
	localparam logic [REG_AW-1:0] GEN_STOP = 7'h10;
	localparam logic [REG_AW-1:0] GEN_SOURCE_ADDR_LOW = 7'h14;
	localparam logic [REG_AW-1:0] GEN_SOURCE_ADDR_HIGH = 7'h18;
	localparam logic [REG_AW-1:0] GEN_DEST_ADDR_LOW = 7'h1c;
	localparam logic [REG_AW-1:0] GEN_DEST_ADDR_HIGH = 7'h20;
	localparam logic [REG_AW-1:0] GEN_SENT_COUNT = 7'h24;
	localparam logic [REG_AW-1:0] GEN_STATUS = 7'h28;
	localparam logic [REG_AW-1:0] GEN_PACKET_LENGTH = 7'h34;
	localparam logic [REG_AW-1:0] MON_BASE = 7'h40;
	localparam logic [REG_AW-1:0] MON_EXPECTED_COUNT = 7'h40;
	localparam logic [REG_AW-1:0] MON_GOOD_COUNT = 7'h44;
	localparam logic [REG_AW-1:0] MON_CRC_BAD_COUNT = 7'h48;
	localparam logic [REG_AW-1:0] MON_BYTE_COUNT_LOW = 7'h4c;
	localparam logic [REG_AW-1:0] MON_BYTE_COUNT_HIGH = 7'h50;
	localparam logic [REG_AW-1:0] MON_CYCLE_COUNT_LOW = 7'h54;
	localparam logic [REG_AW-1:0] MON_CYCLE_COUNT_HIGH = 7'h58;
	localparam logic [REG_AW-1:0] MON_CONTROL_STATUS = 7'h5c;
	localparam logic [REG_AW-1:0] IRQ_STATUS = 7'h60;
	localparam logic [REG_AW-1:0] IRQ_MASK = 7'h64;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int MON_CLEAR_BIT = 0;
	localparam int MON_DONE_BIT = 2;
	localparam int GEN_ACTIVE_BIT = 0;
	localparam logic [31:0] MON_EXPECTED_RST = 32'hffff_ffff;
	localparam int IRQ_N = 3;
	localparam int IRQ_GEN_DONE = 0;
	localparam int IRQ_MON_DONE = 1;
	localparam int IRQ_CRC_BAD = 2;
	localparam logic [63:0] LFSR_SEED = 64'h0123_4567_89ab_cdef;
	localparam logic [63:0] LFSR_TAPS = 64'h0000_0000_0000_001b;

	// ************************************************************
	// Frame layout
	// ************************************************************
	localparam logic [15:0] WORD_BYTES = 16'h0008;
	localparam logic [15:0] MIN_FRAME_BYTES = 16'h0010;

	typedef struct packed {
		logic valid;
		logic sop;
		logic eop;
		logic [2:0] empty;
		logic error;
		logic [63:0] data;
	} etgm_stream_t;

	typedef enum logic [2:0] {
		GEN_IDLE = 3'b000,
		GEN_HDR0 = 3'b001,
		GEN_HDR1 = 3'b010,
		GEN_PAY = 3'b011,
		GEN_NEXT = 3'b100
	} etgm_gen_state_t;

endpackage : etgm_pkg

// File: hw/etgm_top.sv
/*
 * Ethernet traffic generator and monitor: builds bursts of client frames
 * into the MAC transmit stream and counts frames from the MAC receive
 * stream, all under a small register port.
 * Assumes one clock, a MAC that marks CRC failures on the last word, and a
 * register master that follows the one-cycle strobe protocol.
 */
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module etgm_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [etgm_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output etgm_pkg::etgm_stream_t tx_out,
	input wire logic tx_ready,
	input wire etgm_pkg::etgm_stream_t rx_in,
	output logic irq
);
	import etgm_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		etgm_gen_state_t st;
		logic [31:0] pkt_count;
		logic [31:0] pkt_len;
		logic [31:0] sa_lo;
		logic [15:0] sa_hi;
		logic [31:0] da_lo;
		logic [15:0] da_hi;
		logic rnd_len;
		logic rnd_pay;
		logic start_bit;
		logic stop_bit;
		logic stop_pend;
		logic [31:0] sent;
		logic [31:0] remain;
		logic [15:0] bytes_left;
		logic [7:0] pat;
		etgm_stream_t tx;
		logic [31:0] expected;
		logic [31:0] good;
		logic [31:0] bad;
		logic [63:0] rx_bytes;
		logic [63:0] rx_cycles;
		logic started;
		logic done;
		logic [31:0] rdata;
	} etgm_top_state_t;

	etgm_top_state_t s_reg;
	etgm_top_state_t s_next;

	logic adv;
	logic last;
	logic lfsr_adv;
	logic start_pulse;
	logic stop_pulse;
	logic mon_clear;
	logic irq_status_wr;
	logic irq_mask_wr;
	logic [IRQ_N-1:0] ev;
	logic [IRQ_N-1:0] irq_status;
	logic [IRQ_N-1:0] irq_mask;
	logic [63:0] lfsr_val;
	logic [63:0] pat_word;
	logic [63:0] pay_word;
	logic [15:0] len_max;
	logic [15:0] len_spread;
	logic [15:0] len_cand;
	logic [15:0] len_pick;
	logic [31:0] rx_total;

	// ************************************************************
	// Helpers
	// ************************************************************
	etgm_lfsr u_lfsr (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.advance(lfsr_adv),
		.value(lfsr_val)
	);

	etgm_irq u_irq (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.events(ev),
		.status_wr(irq_status_wr),
		.mask_wr(irq_mask_wr),
		.wdata(reg_wdata[IRQ_N-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pat
			assign pat_word[63-8*gi -: 8] = s_reg.pat + 8'(gi);
		end
	endgenerate

	// Masking the random value to the span of the limit and folding the
	// overshoot back keeps the spread near uniform without a divider.
	always_comb begin
		len_max = (|s_reg.pkt_len[31:16]) ? 16'hffff : s_reg.pkt_len[15:0];
		len_spread = len_max | (len_max >> 1);
		len_spread = len_spread | (len_spread >> 2);
		len_spread = len_spread | (len_spread >> 4);
		len_spread = len_spread | (len_spread >> 8);
		len_cand = lfsr_val[15:0] & len_spread;
		if (len_cand > len_max) begin
			len_cand = len_cand - len_max - 16'h0001;
		end
		len_pick = s_reg.rnd_len ? len_cand : len_max;
		// A frame cannot be shorter than its two header words.
		if (len_pick < MIN_FRAME_BYTES) begin
			len_pick = MIN_FRAME_BYTES;
		end
	end

	assign pay_word = s_reg.rnd_pay ? lfsr_val : pat_word;
	// The word register moves whenever it is empty or the MAC takes its word.
	assign adv = !s_reg.tx.valid || tx_ready;
	assign last = s_reg.bytes_left <= WORD_BYTES;
	assign rx_total = s_reg.good + s_reg.bad + 32'h1;
	assign start_pulse = reg_wr && reg_addr == GEN_START;
	assign stop_pulse = reg_wr && reg_addr == GEN_STOP;
	// Clear follows the data bit, so writing zero to the control word is harmless.
	assign mon_clear = reg_wr && reg_addr == MON_CONTROL_STATUS && reg_wdata[MON_CLEAR_BIT];
	assign irq_status_wr = reg_wr && reg_addr == IRQ_STATUS;
	assign irq_mask_wr = reg_wr && reg_addr == IRQ_MASK;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_next = s_reg;
		ev = '0;
		lfsr_adv = 1'b0;
		s_next.rdata = 32'h0;
		if (adv) begin
			s_next.tx.valid = 1'b0;
		end

		if (reg_wr) begin
			unique case (reg_addr)
				GEN_PACKET_COUNT: s_next.pkt_count = reg_wdata;
				GEN_RANDOM_LENGTH_ENABLE: s_next.rnd_len = reg_wdata[0];
				GEN_RANDOM_PAYLOAD_ENABLE: s_next.rnd_pay = reg_wdata[0];
				GEN_START: s_next.start_bit = reg_wdata[0];
				GEN_STOP: s_next.stop_bit = reg_wdata[0];
				GEN_SOURCE_ADDR_LOW: s_next.sa_lo = reg_wdata;
				GEN_SOURCE_ADDR_HIGH: s_next.sa_hi = reg_wdata[15:0];
				GEN_DEST_ADDR_LOW: s_next.da_lo = reg_wdata;
				GEN_DEST_ADDR_HIGH: s_next.da_hi = reg_wdata[15:0];
				GEN_PACKET_LENGTH: s_next.pkt_len = reg_wdata;
				MON_EXPECTED_COUNT: s_next.expected = reg_wdata;
				default: ;
			endcase
		end

		if (stop_pulse && s_reg.st != GEN_IDLE) begin
			s_next.stop_pend = 1'b1;
		end

		// A start while a run is active is ignored, so one run never cuts another short.
		unique case (s_reg.st)
			GEN_IDLE: begin
				if (start_pulse) begin
					s_next.sent = 32'h0;
					s_next.remain = s_reg.pkt_count;
					s_next.stop_pend = 1'b0;
					if (s_reg.pkt_count != 32'h0) begin
						s_next.st = GEN_HDR0;
					end else begin
						ev[IRQ_GEN_DONE] = 1'b1;
					end
				end
			end
			GEN_HDR0: begin
				// A stop seen between frames ends the run before another frame begins.
				if (s_reg.stop_pend) begin
					s_next.st = GEN_IDLE;
					ev[IRQ_GEN_DONE] = 1'b1;
				end else if (adv) begin
					s_next.tx.valid = 1'b1;
					s_next.tx.sop = 1'b1;
					s_next.tx.eop = 1'b0;
					s_next.tx.empty = 3'h0;
					s_next.tx.error = 1'b0;
					s_next.tx.data = {s_reg.da_hi, s_reg.da_lo, s_reg.sa_hi};
					s_next.bytes_left = len_pick - WORD_BYTES;
					s_next.pat = 8'h00;
					lfsr_adv = 1'b1;
					s_next.st = GEN_HDR1;
				end
			end
			GEN_HDR1: begin
				if (adv) begin
					s_next.tx.valid = 1'b1;
					s_next.tx.sop = 1'b0;
					s_next.tx.eop = last;
					s_next.tx.empty = 3'h0;
					// Length field carries the whole frame size; two pad bytes follow.
					s_next.tx.data = {s_reg.sa_lo, s_reg.bytes_left + WORD_BYTES, 16'h0000};
					s_next.bytes_left = s_reg.bytes_left - WORD_BYTES;
					s_next.st = last ? GEN_NEXT : GEN_PAY;
				end
			end
			GEN_PAY: begin
				if (adv) begin
					s_next.tx.valid = 1'b1;
					s_next.tx.sop = 1'b0;
					s_next.tx.eop = last;
					s_next.tx.empty = last ? 3'(4'h8 - s_reg.bytes_left[3:0]) : 3'h0;
					s_next.tx.data = pay_word;
					s_next.pat = s_reg.pat + 8'h08;
					lfsr_adv = s_reg.rnd_pay;
					s_next.bytes_left = last ? 16'h0 : s_reg.bytes_left - WORD_BYTES;
					s_next.st = last ? GEN_NEXT : GEN_PAY;
				end
			end
			GEN_NEXT: begin
				// Here the last word of the frame is being taken by the MAC.
				if (adv) begin
					s_next.sent = s_reg.sent + 32'h1;
					s_next.remain = s_reg.remain - 32'h1;
					if (s_reg.remain == 32'h1 || s_reg.stop_pend) begin
						s_next.st = GEN_IDLE;
						ev[IRQ_GEN_DONE] = 1'b1;
					end else begin
						s_next.st = GEN_HDR0;
					end
				end
			end
			default: s_next.st = GEN_IDLE;
		endcase

		// Monitor side.
		// The receive path has no back-pressure, so every valid word counts at once.
		if (rx_in.valid) begin
			s_next.started = 1'b1;
			s_next.rx_bytes = s_reg.rx_bytes
				+ (rx_in.eop ? 64'(4'h8 - {1'b0, rx_in.empty}) : 64'h8);
			if (rx_in.eop) begin
				if (rx_in.error) begin
					s_next.bad = s_reg.bad + 32'h1;
					ev[IRQ_CRC_BAD] = 1'b1;
				end else begin
					s_next.good = s_reg.good + 32'h1;
				end
				if (rx_total == s_reg.expected && !s_reg.done) begin
					s_next.done = 1'b1;
					ev[IRQ_MON_DONE] = 1'b1;
				end
			end
		end
		if ((s_reg.started || rx_in.valid) && !s_reg.done) begin
			s_next.rx_cycles = s_reg.rx_cycles + 64'h1;
		end
		// Clearing restarts a run, so it deliberately overrides a packet ending now.
		if (mon_clear) begin
			s_next.good = 32'h0;
			s_next.bad = 32'h0;
			s_next.rx_bytes = 64'h0;
			s_next.rx_cycles = 64'h0;
			s_next.started = 1'b0;
			s_next.done = 1'b0;
		end

		// Read data is zero outside the cycle after a read strobe.
		if (reg_rd) begin
			unique case (reg_addr)
				GEN_PACKET_COUNT: s_next.rdata = s_reg.pkt_count;
				GEN_RANDOM_LENGTH_ENABLE: s_next.rdata = {31'h0, s_reg.rnd_len};
				GEN_RANDOM_PAYLOAD_ENABLE: s_next.rdata = {31'h0, s_reg.rnd_pay};
				GEN_START: s_next.rdata = {31'h0, s_reg.start_bit};
				GEN_STOP: s_next.rdata = {31'h0, s_reg.stop_bit};
				GEN_SOURCE_ADDR_LOW: s_next.rdata = s_reg.sa_lo;
				GEN_SOURCE_ADDR_HIGH: s_next.rdata = {16'h0, s_reg.sa_hi};
				GEN_DEST_ADDR_LOW: s_next.rdata = s_reg.da_lo;
				GEN_DEST_ADDR_HIGH: s_next.rdata = {16'h0, s_reg.da_hi};
				GEN_SENT_COUNT: s_next.rdata = s_reg.sent;
				GEN_STATUS: s_next.rdata[GEN_ACTIVE_BIT] = s_reg.st != GEN_IDLE;
				GEN_PACKET_LENGTH: s_next.rdata = s_reg.pkt_len;
				MON_EXPECTED_COUNT: s_next.rdata = s_reg.expected;
				MON_GOOD_COUNT: s_next.rdata = s_reg.good;
				MON_CRC_BAD_COUNT: s_next.rdata = s_reg.bad;
				// The wide counters have no snapshot; read their halves while traffic is quiet.
				MON_BYTE_COUNT_LOW: s_next.rdata = s_reg.rx_bytes[31:0];
				MON_BYTE_COUNT_HIGH: s_next.rdata = s_reg.rx_bytes[63:32];
				MON_CYCLE_COUNT_LOW: s_next.rdata = s_reg.rx_cycles[31:0];
				MON_CYCLE_COUNT_HIGH: s_next.rdata = s_reg.rx_cycles[63:32];
				MON_CONTROL_STATUS: s_next.rdata[MON_DONE_BIT] = s_reg.done;
				IRQ_STATUS: s_next.rdata = {{(32-IRQ_N){1'b0}}, irq_status};
				IRQ_MASK: s_next.rdata = {{(32-IRQ_N){1'b0}}, irq_mask};
				default: s_next.rdata = 32'h0;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// Only the expected count leaves reset non-zero, so it follows the bulk clear.
			s_reg <= '0;
			s_reg.expected <= MON_EXPECTED_RST;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign tx_out = s_reg.tx;
endmodule : etgm_top

// File: verification/etgm_mac_model.sv
/* MAC model: takes tx words, loops each back to the rx stream a cycle later.
 * Assumes the bench sets slow to stall and bad to mark CRC failures. */
`timescale 1ns/1ps
module etgm_mac_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire etgm_pkg::etgm_stream_t tx,
	output logic tx_ready,
	output etgm_pkg::etgm_stream_t rx,
	input wire logic slow,
	input wire logic bad,
	output int frames,
	output longint bytes
);
	import etgm_pkg::*;
	logic tick;
	logic acc;
	assign tx_ready = slow ? tick : 1'b1;
	assign acc = tx.valid && tx_ready;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
			frames <= 0;
			bytes <= 0;
			rx <= '0;
		end else begin
			tick <= ~tick;
			if (acc) begin
				rx <= tx;
				rx.error <= bad && tx.eop;
				bytes <= bytes + (tx.eop ? 8 - tx.empty : 8);
				frames <= frames + (tx.eop ? 1 : 0);
			end else begin
				// Idle words drop valid and invert the data but keep the last eop.
				rx.valid <= 1'b0;
				rx.data <= ~rx.data;
			end
		end
	end
endmodule : etgm_mac_model

// File: verification/etgm_top_chk.sv
/* Port checker of the traffic generator and monitor, bound to etgm_top.
 * Assumes configuration registers are not rewritten while a run is active. */
`timescale 1ns/1ps
module etgm_top_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [etgm_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire etgm_pkg::etgm_stream_t tx_out,
	input wire logic tx_ready,
	input wire etgm_pkg::etgm_stream_t rx_in,
	input wire logic irq
);
	import etgm_pkg::*;
	// ********
	// Shadows
	// ********
	logic [31:0] sa_lo, da_lo, glen, exp_c, pcnt;
	logic [15:0] sa_hi, da_hi, widx, fl;
	logic rlen, rpay;
	// The clamped length is what every fixed-length frame must carry and bounds random ones.
	assign fl = (glen < 32'h10) ? 16'h0010 : (glen > 32'hffff) ? 16'hffff : glen[15:0];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sa_lo <= '0;
			da_lo <= '0;
			sa_hi <= '0;
			da_hi <= '0;
			glen <= '0;
			rlen <= 1'b0;
			rpay <= 1'b0;
			exp_c <= MON_EXPECTED_RST;
			widx <= '0;
			pcnt <= '0;
		end else if (ce) begin
			if (reg_wr) begin
				case (reg_addr)
				GEN_PACKET_COUNT: pcnt <= reg_wdata;
				GEN_SOURCE_ADDR_LOW: sa_lo <= reg_wdata;
				GEN_SOURCE_ADDR_HIGH: sa_hi <= reg_wdata[15:0];
				GEN_DEST_ADDR_LOW: da_lo <= reg_wdata;
				GEN_DEST_ADDR_HIGH: da_hi <= reg_wdata[15:0];
				GEN_PACKET_LENGTH: glen <= reg_wdata;
				GEN_RANDOM_LENGTH_ENABLE: rlen <= reg_wdata[0];
				GEN_RANDOM_PAYLOAD_ENABLE: rpay <= reg_wdata[0];
				MON_EXPECTED_COUNT: exp_c <= reg_wdata;
				default: ;
				endcase
			end
			if (tx_out.valid && tx_ready) begin
				widx <= tx_out.eop ? 16'h0 : widx + 16'h1;
			end
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_hold; tx_out.valid && !tx_ready |=> $stable(tx_out); endproperty
	a_hold: assert property (p_hold) else $error("tx word moved before acceptance");
	property p_gap; tx_out.valid && tx_ready && tx_out.eop |=> !tx_out.valid; endproperty
	a_gap: assert property (p_gap) else $error("no idle cycle after end of frame");
	property p_start;
		reg_wr && reg_addr == GEN_START && !tx_out.valid && pcnt != 32'h0 |->
			##[1:3] tx_out.valid && tx_out.sop;
	endproperty
	a_start: assert property (p_start) else $error("start gave no frame");
	property p_addr; tx_out.valid && tx_out.sop |-> tx_out.data == {da_hi, da_lo, sa_hi}; endproperty
	a_addr: assert property (p_addr) else $error("wrong address word");
	property p_lfix;
		tx_out.valid && widx == 16'h1 && !rlen |-> tx_out.data[63:16] == {sa_lo, fl};
	endproperty
	a_lfix: assert property (p_lfix) else $error("wrong fixed length word");
	property p_lrnd;
		tx_out.valid && widx == 16'h1 && rlen |->
			tx_out.data[31:16] <= fl && tx_out.data[31:16] >= MIN_FRAME_BYTES;
	endproperty
	a_lrnd: assert property (p_lrnd) else $error("random length out of range");
	property p_end;
		tx_out.valid && tx_out.eop && !rlen |->
			tx_out.empty == 3'(16'h0 - fl) && widx == ((fl - 16'h1) >> 3);
	endproperty
	a_end: assert property (p_end) else $error("frame end misplaced");
	property p_pay;
		tx_out.valid && widx == 16'h2 && !rpay |-> tx_out.data == 64'h0001_0203_0405_0607;
	endproperty
	a_pay: assert property (p_pay) else $error("fixed payload wrong");
	property p_rpay;
		tx_out.valid && widx == 16'h2 && rpay |-> tx_out.data != 64'h0001_0203_0405_0607;
	endproperty
	a_rpay: assert property (p_rpay) else $error("random payload looks fixed");
	property p_exp; reg_rd && reg_addr == MON_EXPECTED_COUNT |=> reg_rdata == exp_c; endproperty
	a_exp: assert property (p_exp) else $error("expected count read wrong");
endmodule : etgm_top_chk

bind etgm_top etgm_top_chk i_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tx_out(tx_out), .tx_ready(tx_ready), .rx_in(rx_in), .irq(irq));

// File: verification/test_etgm_top.sv
/* Scenario bench of the traffic generator and monitor with a loop-back MAC.
 * Assumes the checker file binds itself to the top module. */
`timescale 1ns/1ps
module test_etgm_top;
	import etgm_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [REG_AW-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow = 1'b0;
	logic bad = 1'b0;
	logic ce = 1'b1;
	logic [31:0] reg_rdata;
	logic tx_ready;
	logic irq;
	etgm_stream_t tx_out;
	etgm_stream_t rx_in;
	int frames;
	longint bytes;
	int fail_count = 0;
	int samples_checked = 0;
	int f0;
	longint b0;
	logic [31:0] v;
	always #2.5 clock = ~clock;
	etgm_top i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_out(tx_out), .tx_ready(tx_ready), .rx_in(rx_in), .irq(irq));
	etgm_mac_model i_mac (.clock(clock), .rst_n(rst_n), .tx(tx_out), .tx_ready(tx_ready),
		.rx(rx_in), .slow(slow), .bad(bad), .frames(frames), .bytes(bytes));
	// ********
	// Tasks
	// ********
	task automatic end_sim();
		$display("checks %0d failures %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic rdc(input logic [REG_AW-1:0] a, input logic [31:0] e, input string n);
		logic [31:0] d;
		rd(a, d);
		chk(n, e, d);
	endtask : rdc
	// Polls a status bit; a poll that never sees it ends the run.
	task automatic wait_bit(input logic [REG_AW-1:0] a, input int b, input logic e);
		logic [31:0] d;
		for (int i = 0; i < 4000; i++) begin
			rd(a, d);
			if (d[b] === e) return;
		end
		chk("status poll", e, ~e);
		end_sim();
	endtask : wait_bit
	task automatic setup(input logic [31:0] n, input logic [31:0] len, input logic r);
		wr(MON_CONTROL_STATUS, 32'h1);
		wr(MON_EXPECTED_COUNT, n);
		wr(GEN_PACKET_LENGTH, len);
		wr(GEN_PACKET_COUNT, n);
		wr(GEN_RANDOM_LENGTH_ENABLE, {31'h0, r});
		wr(GEN_RANDOM_PAYLOAD_ENABLE, {31'h0, r});
		f0 = frames;
		b0 = bytes;
	endtask : setup
	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		rdc(MON_EXPECTED_COUNT, 32'hffff_ffff, "expected count");
		wr(GEN_SENT_COUNT, 32'h5a5a_5a5a);
		rdc(GEN_SENT_COUNT, 32'h0, "sent count ro");
		rdc(7'h7c, 32'h0, "unmapped");
		rdc(MON_GOOD_COUNT, 32'h0, "good count");
	endtask : t_reset
	task automatic t_fixed();
		wr(GEN_SOURCE_ADDR_LOW, 32'h1122_3344);
		wr(GEN_SOURCE_ADDR_HIGH, 32'h5566);
		wr(GEN_DEST_ADDR_LOW, 32'h8899_aabb);
		wr(GEN_DEST_ADDR_HIGH, 32'hccdd);
		setup(32'h3, 32'h3d, 1'b0);
		slow <= 1'b1;
		rd(MON_CONTROL_STATUS, v);
		chk("done early", 1'b0, v[MON_DONE_BIT]);
		wr(GEN_START, 32'h1);
		wait_bit(GEN_STATUS, GEN_ACTIVE_BIT, 1'b0);
		rdc(GEN_SENT_COUNT, 32'h3, "sent count");
		chk("frames", 3, frames - f0);
		wait_bit(MON_CONTROL_STATUS, MON_DONE_BIT, 1'b1);
		rdc(MON_GOOD_COUNT, 32'h3, "good count");
		rdc(MON_BYTE_COUNT_LOW, 32'hb7, "bytes low");
		rdc(MON_BYTE_COUNT_HIGH, 32'h0, "bytes high");
		rd(MON_CYCLE_COUNT_LOW, v);
		chk("cycles", 1'b1, v >= 32'd24);
		slow <= 1'b0;
	endtask : t_fixed
	task automatic t_random();
		setup(32'h4, 32'h64, 1'b1);
		bad <= 1'b1;
		wr(GEN_START, 32'h1);
		wait_bit(GEN_STATUS, GEN_ACTIVE_BIT, 1'b0);
		rdc(GEN_SENT_COUNT, 32'h4, "sent count");
		wait_bit(MON_CONTROL_STATUS, MON_DONE_BIT, 1'b1);
		rdc(MON_CRC_BAD_COUNT, 32'h4, "bad count");
		rdc(MON_GOOD_COUNT, 32'h0, "good count");
		rdc(MON_BYTE_COUNT_LOW, 32'(bytes - b0), "bytes low");
		bad <= 1'b0;
	endtask : t_random
	task automatic t_stop();
		setup(32'd1000, 32'h40, 1'b0);
		wr(MON_EXPECTED_COUNT, 32'h4);
		wr(GEN_START, 32'h1);
		repeat (40) @(posedge clock);
		wr(GEN_STOP, 32'h1);
		wait_bit(GEN_STATUS, GEN_ACTIVE_BIT, 1'b0);
		rd(GEN_SENT_COUNT, v);
		chk("stopped early", 1'b1, v < 32'd1000 && v > 32'd0);
		chk("sent vs frames", 32'(frames - f0), v);
		rdc(MON_CYCLE_COUNT_LOW, 32'h23, "cycles to done");
	endtask : t_stop
	task automatic t_clear();
		wr(MON_CONTROL_STATUS, 32'h1);
		rdc(MON_GOOD_COUNT, 32'h0, "good cleared");
		rdc(MON_CRC_BAD_COUNT, 32'h0, "bad cleared");
		rdc(MON_BYTE_COUNT_LOW, 32'h0, "bytes cleared");
		rdc(MON_CYCLE_COUNT_LOW, 32'h0, "cycles cleared");
		rdc(MON_CONTROL_STATUS, 32'h0, "done cleared");
		ce <= 1'b0;
		wr(MON_EXPECTED_COUNT, 32'h9);
		ce <= 1'b1;
		rdc(MON_EXPECTED_COUNT, 32'h4, "expected kept");
	endtask : t_clear
	task automatic t_irq();
		rdc(IRQ_STATUS, 32'h7, "irq status");
		chk("irq masked", 1'b0, irq);
		wr(IRQ_MASK, 32'h4);
		rdc(IRQ_MASK, 32'h4, "irq mask");
		chk("irq raised", 1'b1, irq);
		wr(IRQ_STATUS, 32'h4);
		rdc(IRQ_STATUS, 32'h3, "irq cleared");
		chk("irq low", 1'b0, irq);
	endtask : t_irq
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_fixed();
		t_random();
		t_stop();
		t_clear();
		t_irq();
		end_sim();
	end
endmodule : test_etgm_top
